// ---- logic/pmps_top.sv ----
// Power sequencer: key detection, timed rail slots, shutdown paths
module pmps_top import pmps_pkg::*; #(
	parameter int unsigned TICK_CYC = TICK_CYCLES
) (
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic i_main_power_ok,
	input wire logic i_power_key_n,
	input wire logic i_power_key_keep_active_n,
	input wire logic i_shutdown_input_n,
	input wire logic i_cmd_valid,
	input wire pmps_cmd_t i_cmd,
	output pmps_rails_t o_rails,
	output logic o_processor_reset_out_n,
	output pmps_state_t o_state
);

	// Whole state of the block
	typedef struct packed {
		pmps_state_t state;
		logic [2:0] level;
		logic rtc;
		logic armed;
		logic rst_n;
		pmps_rails_t rails;
		logic [31:0] presc;
		logic tick;
		logic [15:0] ms;
		logic [15:0] key_hold;
		logic [15:0] keep_hold;
	} pmps_regs_t;

	localparam logic [31:0] TICK_LAST = 32'(TICK_CYC - 1);
	localparam pmps_regs_t REGS_RESET = '{
		state: ST_OFF,
		level: 3'h0,
		rtc: 1'b0,
		armed: 1'b0,
		rst_n: 1'b0,
		rails: 16'h0000,
		presc: 32'h00000000,
		tick: 1'b0,
		ms: 16'h0000,
		key_hold: 16'h0000,
		keep_hold: 16'h0000
	};

	pmps_regs_t q;
	pmps_regs_t d;
	logic cmd_down;
	logic rtc_off_cmd;
	logic down_req;

	// Rails enabled for a given number of active groups
	function automatic pmps_rails_t rails_of(input logic [2:0] lvl, input logic rtc);
		pmps_rails_t r;
		r = '0;
		r.rtc_ldo = rtc;
		if (lvl >= 3'h1) begin
			r.processor_buck = 1'b1;
		end
		if (lvl >= 3'h2) begin
			r.peripheral_buck = 1'b1;
			r.analog_ldo_a = 1'b1;
			r.io_1v8_ldo = 1'b1;
			r.analog_ldo_b = 1'b1;
		end
		if (lvl >= 3'h3) begin
			r.core_buck = 1'b1;
		end
		if (lvl >= 3'h4) begin
			r.memory_buck = 1'b1;
			r.peripheral_switch = 1'b1;
			r.pll_ldo = 1'b1;
			r.sata_ldo = 1'b1;
		end
		if (lvl >= 3'h5) begin
			r.lcd_io_ldo = 1'b1;
			r.video_dac_ldo = 1'b1;
		end
		if (lvl >= 3'h6) begin
			r.io_3v3_ldo = 1'b1;
			r.expansion_ldo = 1'b1;
			r.supplemental_converter = 1'b1;
		end
		return r;
	endfunction

	// Command and hold decode
	assign cmd_down = i_cmd_valid && (i_cmd == CMD_SHUTDOWN || i_cmd == CMD_STANDBY);
	assign rtc_off_cmd = i_cmd_valid && (i_cmd == CMD_RTC_OFF);
	assign down_req = cmd_down || (q.keep_hold >= HOLD_MS) || (q.key_hold > HOLD_MS)
		|| !i_shutdown_input_n;

	// Next-state logic
	always_comb begin
		d = q;
		// Free-running millisecond tick
		d.tick = 1'b0;
		if (q.presc >= TICK_LAST) begin
			d.presc = 32'h00000000;
			d.tick = 1'b1;
		end else begin
			d.presc = q.presc + 32'h00000001;
		end
		if (q.tick && q.ms != 16'hFFFF) begin
			d.ms = q.ms + 16'h0001;
		end
		// Hold counters run while the rails are coming up or on
		if (i_power_key_n || !(q.state == ST_UP || q.state == ST_ON)) begin
			d.key_hold = 16'h0000;
		end else if (q.tick && q.key_hold != 16'hFFFF) begin
			d.key_hold = q.key_hold + 16'h0001;
		end
		if (i_power_key_keep_active_n || !(q.state == ST_UP || q.state == ST_ON)) begin
			d.keep_hold = 16'h0000;
		end else if (q.tick && q.keep_hold != 16'hFFFF) begin
			d.keep_hold = q.keep_hold + 16'h0001;
		end
		// Key must be seen released before it can start a new sequence
		if (i_power_key_n) begin
			d.armed = 1'b1;
		end
		case (q.state)
			ST_OFF: begin
				d.level = 3'h0;
				if (q.armed && !i_power_key_n) begin
					d.state = ST_UP;
					d.rtc = 1'b1;
					d.ms = 16'h0000;
					d.armed = 1'b0;
				end
			end
			ST_UP: begin
				if (down_req) begin
					d.state = ST_DOWN;
					d.ms = 16'h0000;
					d.armed = 1'b0;
				end else if (q.level == NUM_GROUPS) begin
					d.state = ST_ON;
				end else if (q.ms >= pmps_slot_ms(q.level)) begin
					d.level = q.level + 3'h1;
				end
			end
			ST_ON: begin
				if (down_req) begin
					d.state = ST_DOWN;
					d.ms = 16'h0000;
					d.armed = 1'b0;
				end
			end
			ST_DOWN: begin
				// One group off per step, last enabled first; RTC untouched
				if (q.ms >= DOWN_STEP_MS) begin
					d.ms = 16'h0000;
					if (q.level == 3'h0) begin
						d.state = ST_OFF;
					end else begin
						d.level = q.level - 3'h1;
					end
				end
			end
			default: begin
				d.state = ST_OFF;
			end
		endcase
		// RTC off only by explicit command or loss of input power
		if (rtc_off_cmd) begin
			d.rtc = 1'b0;
		end
		if (!i_main_power_ok) begin
			d.state = ST_OFF;
			d.level = 3'h0;
			d.rtc = 1'b0;
			d.armed = 1'b0;
		end
		d.rails = rails_of(d.level, d.rtc);
		d.rst_n = (d.state == ST_ON);
	end

	// State register, synchronous reset to everything off
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			q <= REGS_RESET;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from flops
	assign o_rails = q.rails;
	assign o_processor_reset_out_n = q.rst_n;
	assign o_state = q.state;

	// Checks
	a_off_rails_low: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		q.state == ST_OFF |-> o_rails[14:0] == 15'h0000)
		else $error("rail enabled while off");

	a_key_starts_up: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(q.state == ST_OFF && q.armed && !i_power_key_n && i_main_power_ok
		&& !rtc_off_cmd) |=> (q.state == ST_UP && o_rails.rtc_ldo))
		else $error("key press did not start sequence");

	a_rtc_first_on: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		$rose(o_rails.processor_buck) |-> $past(o_rails.rtc_ldo))
		else $error("rail enabled before rtc");

	a_rtc_kept_down: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(q.state == ST_DOWN && o_rails.rtc_ldo && i_main_power_ok && !rtc_off_cmd)
		|=> o_rails.rtc_ldo)
		else $error("rtc dropped during power down");

	a_rtc_off_cause: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		$fell(o_rails.rtc_ldo) |-> (!$past(i_main_power_ok) || $past(rtc_off_cmd)))
		else $error("rtc turned off without cause");

	a_group_order: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		o_rails.memory_buck |-> (o_rails.core_buck && o_rails.processor_buck
		&& o_rails.peripheral_buck && o_rails.analog_ldo_b))
		else $error("enable order broken");

	a_slot_first: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		($rose(o_rails.processor_buck) && q.state == ST_UP) |-> $past(q.ms) == SLOT0_MS)
		else $error("processor buck slot wrong");

	a_slot_last: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		($rose(o_rails.io_3v3_ldo) && q.state == ST_UP) |-> $past(q.ms) == SLOT5_MS)
		else $error("last slot wrong");

	a_cmd_powers_down: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(cmd_down && q.state == ST_ON && i_main_power_ok) |=> q.state == ST_DOWN ##1
		o_processor_reset_out_n == 1'b0)
		else $error("command did not start power down");

	a_keep_hold_down: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(q.keep_hold >= HOLD_MS && q.state == ST_ON && i_main_power_ok) |=> q.state == ST_DOWN)
		else $error("keep-active hold ignored");

	a_key_hold_down: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(q.key_hold > HOLD_MS && q.state == ST_ON && i_main_power_ok) |=> q.state == ST_DOWN)
		else $error("long key press ignored");

	a_down_reverse: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		($fell(o_rails.processor_buck) && $past(i_main_power_ok)) |-> (o_rails[14:0] == 15'h0000
		&& $past(o_rails[14:0]) == 15'h4000))
		else $error("power down order broken");

	a_restart_clean: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		$rose(q.state == ST_UP) |-> (q.level == 3'h0 && q.ms == 16'h0000))
		else $error("restart not from first slot");

	a_reset_held: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		o_processor_reset_out_n |-> (o_rails[14:0] == 15'h7FFF && q.state == ST_ON))
		else $error("reset released before rails up");

	a_tick_period: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		q.tick |-> $past(q.presc) == TICK_LAST)
		else $error("tick period wrong");

	// Checks on shutdown input, standby, power loss, reset, rails, level, slots, key hold and power down
	a_sd_pin_down: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(!i_shutdown_input_n && (q.state == ST_UP || q.state == ST_ON) && i_main_power_ok)
		|=> q.state == ST_DOWN)
		else $error("shutdown input ignored");

	a_rtc_kept_standby: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(cmd_down && o_rails.rtc_ldo && i_main_power_ok && !rtc_off_cmd)
		|=> o_rails.rtc_ldo)
		else $error("rtc dropped on standby");

	a_power_lost_off: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		!i_main_power_ok |=> (o_rails[15:0] == 16'h0000 && o_state == ST_OFF
		&& !o_processor_reset_out_n))
		else $error("rails kept after power loss");

	a_reset_low_off: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		q.state != ST_ON |-> !o_processor_reset_out_n)
		else $error("reset released outside on state");

	a_on_rails_full: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		q.state == ST_ON |-> o_rails[14:0] == 15'h7FFF)
		else $error("rail missing in on state");

	a_level_bound: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		q.level <= NUM_GROUPS)
		else $error("group level out of range");

	a_slot_core: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		($rose(o_rails.core_buck) && q.state == ST_UP) |-> $past(q.ms) == SLOT2_MS)
		else $error("core buck slot wrong");

	a_slot_memory: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		($rose(o_rails.memory_buck) && q.state == ST_UP) |-> $past(q.ms) == SLOT3_MS)
		else $error("memory buck slot wrong");

	a_down_no_rise: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		q.state == ST_DOWN |=> (o_rails[15:0] & ~$past(o_rails[15:0])) == 16'h0000)
		else $error("rail enabled during power down");

	a_down_ms_clear: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		$rose(q.state == ST_DOWN) |-> q.ms == 16'h0000)
		else $error("power down step timer not cleared");

	a_key_hold_idle: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(q.state != ST_UP && q.state != ST_ON) |=> q.key_hold == 16'h0000)
		else $error("key hold counted outside up or on");

endmodule

// ---- logic/pmps_pkg.sv ----
// Constants, types and functions for the power sequencer
// Function
// - After power appears, stay off with every sequenced regulator disabled until key press.
// - Power key is active low; low while off starts the power-on sequence.
// - RTC regulator is enabled first, before any timed slot.
// - RTC regulator stays on through system reset and standby; here the i_nrst reset clears it with every other rail.
// - RTC regulator goes off only on input power loss or explicit command.
// - Order: RTC, then core, analog and regulator-input supplies, then the rest.
// - Slots: processor buck 19 ms; peripheral buck, LDO6/8/10 23 ms; core buck 27 ms.
// - Slots: memory buck, switch, LDO2/5 31 ms; LDO4/7 35 ms; LDO3/9, converter 64 ms.
// - A processor shutdown or standby command starts the power-down sequence.
// - Keep-active pin held low at least five seconds requests shutdown.
// - Power key held low over five seconds powers down without the processor.
// - Every shutdown disables rails in reverse power-on order, leaving RTC on.
// - After shutdown the next key press repeats the full power-on sequence.
// - Key and shutdown inputs stay monitored whenever input power is present; here ST_DOWN ignores both, and ST_OFF the shutdown input.
// - Reset output to the processor stays low until every rail is up.
package pmps_pkg;

	// Time base
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned TICK_PERIOD_NS = 1000000;
	localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

	// Slot times in ms after key detection
	localparam logic [15:0] SLOT0_MS = 16'h0013;
	localparam logic [15:0] SLOT1_MS = 16'h0017;
	localparam logic [15:0] SLOT2_MS = 16'h001B;
	localparam logic [15:0] SLOT3_MS = 16'h001F;
	localparam logic [15:0] SLOT4_MS = 16'h0023;
	localparam logic [15:0] SLOT5_MS = 16'h0040;
	localparam logic [2:0] NUM_GROUPS = 3'h6;

	// Five-second hold and power-down step, in ms
	localparam logic [15:0] HOLD_MS = 16'h1388;
	localparam logic [15:0] DOWN_STEP_MS = 16'h0004;

	// Sequencer states
	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_UP = 2'b01,
		ST_ON = 2'b10,
		ST_DOWN = 2'b11
	} pmps_state_t;

	// Processor commands
	typedef enum logic [1:0] {
		CMD_SHUTDOWN = 2'b00,
		CMD_STANDBY = 2'b01,
		CMD_RTC_OFF = 2'b10,
		CMD_NOP = 2'b11
	} pmps_cmd_t;

	// Regulator enables, RTC in the top bit
	typedef struct packed {
		logic rtc_ldo;
		logic processor_buck;
		logic peripheral_buck;
		logic analog_ldo_a;
		logic io_1v8_ldo;
		logic analog_ldo_b;
		logic core_buck;
		logic memory_buck;
		logic peripheral_switch;
		logic pll_ldo;
		logic sata_ldo;
		logic lcd_io_ldo;
		logic video_dac_ldo;
		logic io_3v3_ldo;
		logic expansion_ldo;
		logic supplemental_converter;
	} pmps_rails_t;

	// Slot time of each group
	function automatic logic [15:0] pmps_slot_ms(input logic [2:0] grp);
		case (grp)
			3'h0: pmps_slot_ms = SLOT0_MS;
			3'h1: pmps_slot_ms = SLOT1_MS;
			3'h2: pmps_slot_ms = SLOT2_MS;
			3'h3: pmps_slot_ms = SLOT3_MS;
			3'h4: pmps_slot_ms = SLOT4_MS;
			default: pmps_slot_ms = SLOT5_MS;
		endcase
	endfunction

endpackage

// ---- sim/pmps_proc_model.sv ----
// Processor-side model: command strobes and keep-active pin
module pmps_proc_model import pmps_pkg::*; (
	input wire logic i_sys_clk,
	output logic o_cmd_valid,
	output pmps_cmd_t o_cmd,
	output logic o_keep_n
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle: no strobe, pin released to its pull-up
	initial begin
		o_cmd_valid = 1'b0;
		o_cmd = CMD_NOP;
		o_keep_n = 1'b1;
	end

	// One-cycle command strobe launched at a falling edge
	task send(input pmps_cmd_t c);
		@(negedge i_sys_clk);
		o_cmd_valid = 1'b1;
		o_cmd = c;
		@(negedge i_sys_clk);
		o_cmd_valid = 1'b0;
		o_cmd = CMD_NOP;
	endtask

	// Keep-active pin pulled low or released
	task keep(input logic low);
		@(negedge i_sys_clk);
		o_keep_n = ~low;
	endtask
endmodule

// ---- sim/pmps_top_test.sv ----
// Self-checking bench for the power sequencer
module pmps_top_test import pmps_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int T = 4;
	localparam int H = 5000;
	logic clk = 1'b0;
	logic nrst, pwr_ok, key_n, sd_n, cmd_valid, keep_n, rst_out_n;
	pmps_cmd_t cmd;
	pmps_rails_t rails;
	pmps_state_t state;
	int bad_count, checked, cyc;
	int slot_ms[6] = '{19, 23, 27, 31, 35, 64};
	logic [15:0] up_mask[6] = '{16'hC000, 16'hFC00, 16'hFE00, 16'hFFE0, 16'hFFF8, 16'hFFFF};

	// 200 MHz clock
	always #2.5 clk = ~clk;

	pmps_top #(.TICK_CYC(T)) pmps_top_inst (.i_sys_clk(clk), .i_nrst(nrst),
		.i_main_power_ok(pwr_ok), .i_power_key_n(key_n),
		.i_power_key_keep_active_n(keep_n), .i_shutdown_input_n(sd_n),
		.i_cmd_valid(cmd_valid), .i_cmd(cmd), .o_rails(rails),
		.o_processor_reset_out_n(rst_out_n), .o_state(state));

	pmps_proc_model pmps_proc_model_inst (.i_sys_clk(clk), .o_cmd_valid(cmd_valid),
		.o_cmd(cmd), .o_keep_n(keep_n));

	task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Verdict and end of run
	task final_report();
		if (bad_count == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc > 60000) begin
			bad_count++;
			final_report();
		end
	end

	// Waits for the rails to change, bounded
	task wait_rails(output int n);
		logic [15:0] p;
		p = rails;
		n = 0;
		while (rails === p && n < 400) begin
			@(negedge clk);
			n++;
		end
	endtask

	task power_on(input logic [15:0] idle);
		int n, t;
		t = 0;
		chk("rails_idle", rails, idle);
		key_n = 1'b0;
		@(negedge clk);
		key_n = 1'b1;
		chk("state_up", state, ST_UP);
		chk("rtc_first", rails, 16'h8000);
		for (int g = 0; g < 6; g++) begin
			wait_rails(n);
			t += n;
			chk("group_rails", rails, up_mask[g]);
			chk("group_time", t >= (slot_ms[g] - 1) * T && t <= slot_ms[g] * T + 2, 1'b1);
			chk("reset_held", rst_out_n, 1'b0);
		end
		@(negedge clk);
		chk("state_on", state, ST_ON);
		chk("reset_free", rst_out_n, 1'b1);
	endtask

	task power_down();
		int n;
		chk("state_down", state, ST_DOWN);
		chk("reset_down", rst_out_n, 1'b0);
		for (int g = 4; g >= 0; g--) begin
			wait_rails(n);
			chk("down_rails", rails, up_mask[g]);
		end
		n = 0;
		while (state !== ST_OFF && n < 40) begin
			@(negedge clk);
			n++;
		end
		chk("state_off", state, ST_OFF);
		chk("rtc_kept", rails, 16'h8000);
	endtask

	// Long hold on the key or on the keep-active pin
	task hold_case(input logic use_key);
		int n, lo;
		lo = use_key ? H * T : (H - 1) * T;
		power_on(16'h8000);
		if (use_key) begin
			@(negedge clk);
			key_n = 1'b0;
		end else begin
			pmps_proc_model_inst.keep(1'b1);
		end
		n = 0;
		while (state === ST_ON && n < 30000) begin
			@(negedge clk);
			n++;
		end
		chk("hold_time", n >= lo && n <= lo + T + 2, 1'b1);
		power_down();
		key_n = 1'b1;
		pmps_proc_model_inst.keep(1'b0);
	endtask

	// Main sequence
	initial begin
		nrst = 1'b0;
		pwr_ok = 1'b1;
		key_n = 1'b1;
		sd_n = 1'b1;
		repeat (12) @(negedge clk);
		nrst = 1'b1;
		repeat (3) @(negedge clk);
		power_on(16'h0000);
		pmps_proc_model_inst.send(CMD_SHUTDOWN);
		power_down();
		power_on(16'h8000);
		pmps_proc_model_inst.send(CMD_STANDBY);
		power_down();
		hold_case(1'b0);
		hold_case(1'b1);
		power_on(16'h8000);
		sd_n = 1'b0;
		@(negedge clk);
		sd_n = 1'b1;
		power_down();
		pmps_proc_model_inst.send(CMD_RTC_OFF);
		chk("rtc_off", rails, 16'h0000);
		power_on(16'h0000);
		pwr_ok = 1'b0;
		@(negedge clk);
		chk("power_lost", rails, 16'h0000);
		chk("state_lost", state, ST_OFF);
		pwr_ok = 1'b1;
		repeat (20) @(negedge clk);
		power_on(16'h0000);
		final_report();
	end
endmodule
